// ==== hw/nvm_bank_map.svh ====
/*
 * Register offsets, field positions, reset values and decoded values for the
 * user configuration bank. Assumes inclusion by bare name, after the package.
 */
`ifndef NVM_BANK_MAP_SVH
`define NVM_BANK_MAP_SVH

// ****************************************************************
// Offsets and layout
// ****************************************************************
`define OFS_CONV_A 7'h0A
`define OFS_CONV_B 7'h0B
`define OFS_CONV_C 7'h0C
`define OFS_USER 7'h0D
`define WORD_RST 24'h000000
`define PAYLOAD_MASK 24'h0FFFF0
`define USER_HI 19
`define USER_LO 4
// Converters A and B
`define AB_RATE 19
`define AB_LVL_HI 18
`define AB_LVL_LO 17
`define AB_ON_HI 16
`define AB_ON_LO 14
`define AB_OFF_HI 13
`define AB_OFF_LO 11
`define AB_PK_HI 10
`define AB_PK_LO 8
// Converter C
`define C_BYPASS 19
`define C_LVL_HI 18
`define C_LVL_LO 16
`define C_ON_HI 15
`define C_ON_LO 13
`define C_OFF_HI 12
`define C_OFF_LO 10
`define C_PK_HI 9
`define C_PK_LO 8
// Common low byte
`define F_POLICY 7
`define F_SLOPE_HI 6
`define F_SLOPE_LO 5
`define F_REFRESH 4

// ****************************************************************
// Decoded values: level 10 mV, slope 10 mV/ms, current 100 mA, rates kHz
// ****************************************************************
`define STEP_LAST 3'h7
`define STEP_OFF_CAP 3'h6
`define LVL_OFF 10'h000
`define LVL_0V98 10'h062
`define LVL_1V1 10'h06E
`define LVL_1V2 10'h078
`define LVL_1V25 10'h07D
`define LVL_3V3 10'h14A
`define LVL_5V0 10'h1F4
`define LVL_6V5 10'h28A
`define SS_16V5 11'h672
`define SS_8V25 11'h339
`define SS_3V3 11'h14A
`define SS_1V65 11'h0A5
`define SS_8V7 11'h366
`define SS_4V35 11'h1B3
`define SS_1V75 11'h0AF
`define SS_0V87 11'h057
`define PK_BASE 7'h14
`define PK_STEP 7'h05
`define PK_CAP 3'h6
`define PK_4A0 7'h28
`define PK_5A0 7'h32
`define PK_6A0 7'h3C
`define PK_7A2 7'h48
`define RATE_0M4 12'h190
`define RATE_2M4 12'h960
`define REFR_1K 5'h01
`define REFR_25K 5'h19

`endif

// ==== hw/nvm_bank_pkg.sv ====
/*
 * Types shared by the configuration bank and its decoders.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nvm_bank_pkg;
    typedef struct packed {
        logic [2:0] on_step;
        logic [2:0] off_step;
        logic [6:0] peak;
        logic [9:0] level;
        logic [10:0] slope;
        logic [11:0] switch_khz;
        logic [4:0] refresh_khz;
        logic policy;
    } conv_cfg_t;

    typedef struct packed {
        logic uv;
        logic ov;
        logic pgl;
        logic tw;
        logic thermal_shutdown;
    } fault_t;

    typedef struct packed {
        logic uv_irq;
        logic ov_irq;
        logic pgl_irq;
        logic tw_irq;
        logic uv_off;
        logic pgl_off;
    } fault_mask_t;

    typedef struct packed {
        logic go_recovery;
        logic irq;
        logic turn_off;
    } reaction_t;

    typedef struct packed {
        logic [2:0] conv_a;
        logic [2:0] conv_b;
        logic [2:0] conv_c;
    } steps_t;
endpackage

// ==== hw/cfg_decode.sv ====
/*
 * Decodes one stored configuration word into physical settings.
 * Assumes the word holds only payload bits; purely combinational.
 */
`timescale 1ns/1ps
`include "nvm_bank_map.svh"

module cfg_decode #(
    parameter bit IS_C = 1'b0
) (
    input wire logic [23:0] word,
    output nvm_bank_pkg::conv_cfg_t cfg
);
    // ****************************************************************
    // Field decoders: off_step for all three, peak_ab for A and B only
    // ****************************************************************
    function automatic logic [2:0] off_step(input logic [2:0] code);
        off_step = (code >= `STEP_OFF_CAP) ? `STEP_LAST : code + 3'h1;
    endfunction

    function automatic logic [6:0] peak_ab(input logic [2:0] code);
        logic [2:0] c;
        c = (code >= `PK_CAP) ? `PK_CAP : code;
        peak_ab = `PK_BASE + 7'(c * `PK_STEP);
    endfunction

    always_comb begin
        cfg = '0;
        cfg.policy = word[`F_POLICY];
        cfg.refresh_khz = word[`F_REFRESH] ? `REFR_1K : `REFR_25K;
        if (IS_C) begin
            // Turn-on code is already the step number, 0 meaning never
            cfg.on_step = word[`C_ON_HI:`C_ON_LO];
            cfg.off_step = off_step(word[`C_OFF_HI:`C_OFF_LO]);
            // Switching rate of this converter is fixed
            cfg.switch_khz = `RATE_2M4;
            case (word[`C_LVL_HI:`C_LVL_LO])
                3'h1: cfg.level = `LVL_0V98;
                3'h2: cfg.level = `LVL_1V1;
                3'h3: cfg.level = `LVL_1V2;
                3'h4: cfg.level = `LVL_1V25;
                3'h0: cfg.level = `LVL_OFF;
                default: cfg.level = `LVL_3V3;
            endcase
            case (word[`C_PK_HI:`C_PK_LO])
                2'h0: cfg.peak = `PK_4A0;
                2'h1: cfg.peak = `PK_5A0;
                2'h2: cfg.peak = `PK_6A0;
                default: cfg.peak = `PK_7A2;
            endcase
            case (word[`F_SLOPE_HI:`F_SLOPE_LO])
                2'h0: cfg.slope = `SS_8V7;
                2'h1: cfg.slope = `SS_4V35;
                2'h2: cfg.slope = `SS_1V75;
                default: cfg.slope = `SS_0V87;
            endcase
        end else begin
            cfg.on_step = word[`AB_ON_HI:`AB_ON_LO];
            cfg.off_step = off_step(word[`AB_OFF_HI:`AB_OFF_LO]);
            cfg.peak = peak_ab(word[`AB_PK_HI:`AB_PK_LO]);
            cfg.switch_khz = word[`AB_RATE] ? `RATE_0M4 : `RATE_2M4;
            case (word[`AB_LVL_HI:`AB_LVL_LO])
                2'h0: cfg.level = `LVL_3V3;
                2'h1: cfg.level = `LVL_5V0;
                default: cfg.level = `LVL_6V5;
            endcase
            case (word[`F_SLOPE_HI:`F_SLOPE_LO])
                2'h0: cfg.slope = `SS_16V5;
                2'h1: cfg.slope = `SS_8V25;
                2'h2: cfg.slope = `SS_3V3;
                default: cfg.slope = `SS_1V65;
            endcase
        end
    end
endmodule

// ==== hw/fault_policy.sv ====
/*
 * Reaction of one converter to its fault flags under the recovery policy bit.
 * Assumes fault flags are levels sampled by the caller; combinational.
 */
`timescale 1ns/1ps

module fault_policy (
    input wire logic policy,
    input wire nvm_bank_pkg::fault_t fault,
    input wire nvm_bank_pkg::fault_mask_t mask,
    output nvm_bank_pkg::reaction_t react
);
    always_comb begin
        // Thermal warning is a warning only, so it never forces recovery
        react.go_recovery = policy & (fault.uv | fault.ov | fault.pgl | fault.thermal_shutdown);
        // Thermal shutdown cannot be masked from the interrupt
        react.irq = ~policy & ((fault.uv & ~mask.uv_irq) | (fault.ov & ~mask.ov_irq) |
                               (fault.pgl & ~mask.pgl_irq) | (fault.tw & ~mask.tw_irq) |
                               fault.thermal_shutdown);
        react.turn_off = ~policy & ((fault.uv & ~mask.uv_off) | (fault.pgl & ~mask.pgl_off) |
                                    fault.ov | fault.thermal_shutdown);
    end
endmodule

// ==== hw/nvm_config_bank.sv ====
/*
 * User configuration bank: four words, a parallel register port, decoded
 * settings, fault reactions, bypass control and sequence step snapshots.
 * Assumes the serial frame layer sits outside and fills the check field.
 */
`timescale 1ns/1ps
`include "nvm_bank_map.svh"

module nvm_config_bank (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Register port
    input wire logic REG_REQ,
    input wire logic REG_WRITE,
    input wire logic [6:0] REG_ADDR,
    input wire logic [23:0] REG_WDATA,
    output logic [23:0] REG_RDATA,
    output logic REG_ACK,
    output logic REG_REFUSED,
    // Programming state
    input wire logic PROG_STATE,
    input wire logic PROG_DONE,
    output logic LOCKED,
    // Sequencer
    input wire logic SEQ_UP_START,
    input wire logic SEQ_DOWN_START,
    output nvm_bank_pkg::steps_t UP_STEPS,
    output nvm_bank_pkg::steps_t DOWN_STEPS,
    // Decoded settings
    output nvm_bank_pkg::conv_cfg_t CONV_A_CFG,
    output nvm_bank_pkg::conv_cfg_t CONV_B_CFG,
    output nvm_bank_pkg::conv_cfg_t CONV_C_CFG,
    output logic [15:0] USER_GENERAL_WORD,
    // Faults
    input wire nvm_bank_pkg::fault_t FAULT_A,
    input wire nvm_bank_pkg::fault_t FAULT_B,
    input wire nvm_bank_pkg::fault_t FAULT_C,
    input wire nvm_bank_pkg::fault_mask_t FAULT_MASK,
    output nvm_bank_pkg::reaction_t REACT_A,
    output nvm_bank_pkg::reaction_t REACT_B,
    output nvm_bank_pkg::reaction_t REACT_C,
    // Battery bypass
    input wire logic VBAT_WANTS_BYPASS,
    output logic BYPASS_ON
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_q1_r;
    logic rst_q2_r;
    logic rst_n;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_q1_r <= 1'b0;
            rst_q2_r <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_q2_r <= rst_q1_r;
        end
    end
    assign rst_n = rst_q2_r;

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [23:0] word_r [4];
    logic [23:0] word_nxt [4];
    logic locked_r;
    logic locked_nxt;
    logic ack_r;
    logic ack_nxt;
    logic refused_r;
    logic refused_nxt;
    logic [23:0] rdata_r;
    logic [23:0] rdata_nxt;
    logic hit;
    logic [1:0] idx;

    function automatic logic [1:0] word_index(input logic [6:0] addr);
        // A literal cannot be part-selected, so subtract at full width and cut
        word_index = 2'(addr - `OFS_CONV_A);
    endfunction

    always_comb begin
        hit = (REG_ADDR >= `OFS_CONV_A) && (REG_ADDR <= `OFS_USER);
        idx = word_index(REG_ADDR);
        word_nxt = word_r;
        // Lock is sticky until reset; completion never reopens emulation
        locked_nxt = locked_r | PROG_DONE;
        ack_nxt = REG_REQ;
        refused_nxt = 1'b0;
        rdata_nxt = 24'h000000;
        if (REG_REQ) begin
            if (!hit) begin
                refused_nxt = REG_WRITE;
            end else if (REG_WRITE) begin
                // Emulation writes only in the first programming state, before lock
                if (PROG_STATE && !locked_r) begin
                    // Reserved top bits and check field are never stored
                    word_nxt[idx] = REG_WDATA & `PAYLOAD_MASK;
                end else begin
                    refused_nxt = 1'b1;
                end
            end else begin
                // Check field reads zero here; the frame layer inserts it
                rdata_nxt = word_r[idx];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                word_r[i] <= `WORD_RST;
            end
            locked_r <= 1'b0;
            ack_r <= 1'b0;
            refused_r <= 1'b0;
            rdata_r <= 24'h000000;
        end else begin
            word_r <= word_nxt;
            locked_r <= locked_nxt;
            ack_r <= ack_nxt;
            refused_r <= refused_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_ACK = ack_r;
    assign REG_REFUSED = refused_r;
    assign REG_RDATA = rdata_r;
    assign LOCKED = locked_r;

    // ****************************************************************
    // Decoders and fault reactions
    // ****************************************************************
    nvm_bank_pkg::conv_cfg_t dec_a;
    nvm_bank_pkg::conv_cfg_t dec_b;
    nvm_bank_pkg::conv_cfg_t dec_c;
    nvm_bank_pkg::reaction_t re_a;
    nvm_bank_pkg::reaction_t re_b;
    nvm_bank_pkg::reaction_t re_c;

    cfg_decode #(.IS_C(1'b0)) u_dec_a (
        .word(word_r[0]),
        .cfg(dec_a)
    );
    cfg_decode #(.IS_C(1'b0)) u_dec_b (
        .word(word_r[1]),
        .cfg(dec_b)
    );
    cfg_decode #(.IS_C(1'b1)) u_dec_c (
        .word(word_r[2]),
        .cfg(dec_c)
    );

    fault_policy u_pol_a (
        .policy(dec_a.policy),
        .fault(FAULT_A),
        .mask(FAULT_MASK),
        .react(re_a)
    );
    fault_policy u_pol_b (
        .policy(dec_b.policy),
        .fault(FAULT_B),
        .mask(FAULT_MASK),
        .react(re_b)
    );
    fault_policy u_pol_c (
        .policy(dec_c.policy),
        .fault(FAULT_C),
        .mask(FAULT_MASK),
        .react(re_c)
    );

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    nvm_bank_pkg::conv_cfg_t cfg_a_r;
    nvm_bank_pkg::conv_cfg_t cfg_b_r;
    nvm_bank_pkg::conv_cfg_t cfg_c_r;
    nvm_bank_pkg::reaction_t react_a_r;
    nvm_bank_pkg::reaction_t react_b_r;
    nvm_bank_pkg::reaction_t react_c_r;
    logic [15:0] user_r;
    logic bypass_r;
    logic bypass_nxt;

    always_comb begin
        // Disable wins over the battery sense request
        bypass_nxt = ~word_r[2][`C_BYPASS] & VBAT_WANTS_BYPASS;
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cfg_a_r <= '0;
            cfg_b_r <= '0;
            cfg_c_r <= '0;
            react_a_r <= '0;
            react_b_r <= '0;
            react_c_r <= '0;
            user_r <= 16'h0000;
            bypass_r <= 1'b0;
        end else begin
            cfg_a_r <= dec_a;
            cfg_b_r <= dec_b;
            cfg_c_r <= dec_c;
            react_a_r <= re_a;
            react_b_r <= re_b;
            react_c_r <= re_c;
            user_r <= word_r[3][`USER_HI:`USER_LO];
            bypass_r <= bypass_nxt;
        end
    end

    assign CONV_A_CFG = cfg_a_r;
    assign CONV_B_CFG = cfg_b_r;
    assign CONV_C_CFG = cfg_c_r;
    assign REACT_A = react_a_r;
    assign REACT_B = react_b_r;
    assign REACT_C = react_c_r;
    assign USER_GENERAL_WORD = user_r;
    assign BYPASS_ON = bypass_r;

    // ****************************************************************
    // Sequence step snapshots
    // ****************************************************************
    // Held copies keep a running sequence stable if software rewrites a word
    nvm_bank_pkg::steps_t up_r;
    nvm_bank_pkg::steps_t up_nxt;
    nvm_bank_pkg::steps_t down_r;
    nvm_bank_pkg::steps_t down_nxt;

    always_comb begin
        up_nxt = up_r;
        down_nxt = down_r;
        if (SEQ_UP_START) begin
            up_nxt.conv_a = dec_a.on_step;
            up_nxt.conv_b = dec_b.on_step;
            up_nxt.conv_c = dec_c.on_step;
        end
        if (SEQ_DOWN_START) begin
            down_nxt.conv_a = dec_a.off_step;
            down_nxt.conv_b = dec_b.off_step;
            down_nxt.conv_c = dec_c.off_step;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= '0;
            down_r <= '0;
        end else begin
            up_r <= up_nxt;
            down_r <= down_nxt;
        end
    end

    assign UP_STEPS = up_r;
    assign DOWN_STEPS = down_r;
endmodule

// ==== tb/nvm_config_bank_asserts.sv ====
/*
 * Port checker for the configuration bank, attached by bind.
 * Assumes the single system clock domain and the active-low reset pin.
 */
`timescale 1ns/1ps

module nvm_config_bank_asserts (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Register port
    input wire logic REG_REQ,
    input wire logic REG_WRITE,
    input wire logic [23:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire logic REG_REFUSED,
    // Programming and sequencer
    input wire logic PROG_STATE,
    input wire logic PROG_DONE,
    input wire logic LOCKED,
    input wire logic SEQ_UP_START,
    input wire nvm_bank_pkg::steps_t UP_STEPS,
    // Settings, faults and bypass
    input wire nvm_bank_pkg::conv_cfg_t CONV_A_CFG,
    input wire nvm_bank_pkg::conv_cfg_t CONV_B_CFG,
    input wire nvm_bank_pkg::conv_cfg_t CONV_C_CFG,
    input wire nvm_bank_pkg::fault_t FAULT_A,
    input wire nvm_bank_pkg::fault_t FAULT_B,
    input wire nvm_bank_pkg::fault_t FAULT_C,
    input wire nvm_bank_pkg::reaction_t REACT_A,
    input wire nvm_bank_pkg::reaction_t REACT_B,
    input wire nvm_bank_pkg::reaction_t REACT_C,
    input wire logic VBAT_WANTS_BYPASS,
    input wire logic BYPASS_ON
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence s_write_req;
        REG_REQ && REG_WRITE;
    endsequence
    // Decoded settings lag the store by one edge just after a write
    sequence s_settled;
        !REG_ACK;
    endsequence

    // ****************************************************************
    // Properties
    // ****************************************************************
    a_ack_follows: assert property (REG_REQ |=> REG_ACK)
        else $error("request not answered one cycle later");
    a_idle_quiet: assert property (!REG_REQ |=> !REG_ACK && !REG_REFUSED && REG_RDATA == 24'h000000)
        else $error("answer without request");
    a_refuse_unprog: assert property (s_write_req ##0 !PROG_STATE |=> REG_REFUSED)
        else $error("write outside programming state accepted");
    a_refuse_locked: assert property (s_write_req ##0 LOCKED |=> REG_REFUSED)
        else $error("write after lock accepted");
    a_reserved_zero: assert property (REG_ACK |-> REG_RDATA[23:20] == 4'h0 && REG_RDATA[3:0] == 4'h0)
        else $error("reserved or check bits read nonzero");
    a_lock_sticky: assert property (PROG_DONE || LOCKED |=> LOCKED)
        else $error("lock not set or lost");
    a_steps_held: assert property (!SEQ_UP_START |=> $stable(UP_STEPS))
        else $error("turn-on steps changed mid sequence");
    a_bypass_gated: assert property (!VBAT_WANTS_BYPASS |=> !BYPASS_ON)
        else $error("bypass on without battery request");
    a_policy_recover: assert property (s_settled ##0 CONV_A_CFG.policy && FAULT_A.uv |=> REACT_A.go_recovery)
        else $error("fault did not enter recovery");
    a_ov_turns_off: assert property (s_settled ##0 !CONV_B_CFG.policy && FAULT_B.ov |=> REACT_B.turn_off)
        else $error("overvoltage left converter on");
    a_warn_stays_on: assert property (s_settled ##0 !CONV_C_CFG.policy && FAULT_C == 5'h02 |=> !REACT_C.turn_off)
        else $error("thermal warning switched converter off");
    a_tsd_irq: assert property (s_settled ##0 !CONV_A_CFG.policy && FAULT_A.thermal_shutdown |=> REACT_A.irq && REACT_A.turn_off)
        else $error("shutdown fault without interrupt and turn-off");
endmodule

bind nvm_config_bank nvm_config_bank_asserts nvm_config_bank_asserts_inst (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .REG_REQ(REG_REQ), .REG_WRITE(REG_WRITE), .REG_RDATA(REG_RDATA),
    .REG_ACK(REG_ACK), .REG_REFUSED(REG_REFUSED), .PROG_STATE(PROG_STATE), .PROG_DONE(PROG_DONE),
    .LOCKED(LOCKED), .SEQ_UP_START(SEQ_UP_START), .UP_STEPS(UP_STEPS), .CONV_A_CFG(CONV_A_CFG),
    .CONV_B_CFG(CONV_B_CFG), .CONV_C_CFG(CONV_C_CFG), .FAULT_A(FAULT_A), .FAULT_B(FAULT_B), .FAULT_C(FAULT_C),
    .REACT_A(REACT_A), .REACT_B(REACT_B), .REACT_C(REACT_C), .VBAT_WANTS_BYPASS(VBAT_WANTS_BYPASS),
    .BYPASS_ON(BYPASS_ON)
);

// ==== tb/reg_host_model.sv ====
/*
 * Host side of the register port: one pulsed request per call.
 * Assumes the device answers exactly one cycle after taking a request.
 */
`timescale 1ns/1ps

module reg_host_model (
    // Clock
    input wire logic clk_sys,
    // Request
    output logic req,
    output logic write,
    output logic [6:0] addr,
    output logic [23:0] wdata,
    // Answer
    input wire logic [23:0] rdata,
    input wire logic ack,
    input wire logic refused
);
    initial begin
        req = 1'b0;
        write = 1'b0;
        addr = 7'h00;
        wdata = 24'h000000;
    end

    // ****************************************************************
    // Access
    // ****************************************************************
    task automatic access(input logic w, input logic [6:0] a, input logic [23:0] d,
                          output logic [23:0] rd, output logic ok, output logic rf);
        @(negedge clk_sys);
        req = 1'b1;
        write = w;
        addr = a;
        wdata = {d[23:4], 4'h5}; // Frame layer owns the low nibble
        @(negedge clk_sys);
        req = 1'b0;
        // Released lines flip so a stale value cannot pass for a held one
        write = ~write;
        addr = ~addr;
        wdata = ~wdata;
        rd = rdata;
        ok = ack;
        rf = refused;
    endtask
endmodule

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the configuration bank.
 * Assumes the host model drives the register port at falling edges.
 */
`timescale 1ns/1ps
`include "nvm_bank_map.svh"

module testbench;
    logic clk_sys, resetn, req, write, ack, refused, prog_state, prog_done, locked, seq_up, seq_down;
    logic vbat, bypass_on;
    logic [6:0] addr;
    logic [23:0] wdata, rdata, wab, wc;
    logic [15:0] user_word;
    logic [2:0] k;
    nvm_bank_pkg::steps_t up_steps, down_steps;
    nvm_bank_pkg::conv_cfg_t cfg_a, cfg_b, cfg_c;
    nvm_bank_pkg::fault_t fault_a, fault_b, fault_c;
    nvm_bank_pkg::fault_mask_t fmask;
    nvm_bank_pkg::reaction_t react_a, react_b, react_c;
    nvm_bank_pkg::fault_t ft [8] = '{5'h08, 5'h02, 5'h10, 5'h10, 5'h01, 5'h04, 5'h02, 5'h08};
    nvm_bank_pkg::fault_mask_t mt [8] = '{6'h00, 6'h00, 6'h02, 6'h20, 6'h3F, 6'h01, 6'h04, 6'h3F};
    nvm_bank_pkg::reaction_t rt [8] = '{3'h3, 3'h2, 3'h2, 3'h1, 3'h3, 3'h2, 3'h0, 3'h1};
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    nvm_config_bank nvm_config_bank_inst (
        .CLK_SYS(clk_sys), .RESETN(resetn), .REG_REQ(req), .REG_WRITE(write), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack), .REG_REFUSED(refused), .PROG_STATE(prog_state),
        .PROG_DONE(prog_done), .LOCKED(locked), .SEQ_UP_START(seq_up), .SEQ_DOWN_START(seq_down),
        .UP_STEPS(up_steps), .DOWN_STEPS(down_steps), .CONV_A_CFG(cfg_a), .CONV_B_CFG(cfg_b), .CONV_C_CFG(cfg_c),
        .USER_GENERAL_WORD(user_word), .FAULT_A(fault_a), .FAULT_B(fault_b), .FAULT_C(fault_c),
        .FAULT_MASK(fmask), .REACT_A(react_a), .REACT_B(react_b), .REACT_C(react_c),
        .VBAT_WANTS_BYPASS(vbat), .BYPASS_ON(bypass_on)
    );
    reg_host_model reg_host_model_inst (
        .clk_sys(clk_sys), .req(req), .write(write), .addr(addr), .wdata(wdata), .rdata(rdata),
        .ack(ack), .refused(refused)
    );

    // ****************************************************************
    // Checking and access tasks
    // ****************************************************************
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [23:0] d, input logic exp_rf);
        logic [23:0] rd;
        logic ok, rf;
        reg_host_model_inst.access(1'b1, a, d, rd, ok, rf);
        chk("write ack", ok, 1'b1);
        chk("refused", rf, exp_rf);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [23:0] e);
        logic [23:0] rd;
        logic ok, rf;
        reg_host_model_inst.access(1'b0, a, 24'h000000, rd, ok, rf);
        chk("read ack", ok & ~rf, 1'b1);
        chk("rdata", rd, e);
    endtask

    // Expected decode of a converter A or B word built from code k in every field
    function automatic nvm_bank_pkg::conv_cfg_t ab_exp(input logic [2:0] i);
        logic [9:0] lvl [4] = '{`LVL_3V3, `LVL_5V0, `LVL_6V5, `LVL_6V5};
        logic [10:0] ss [4] = '{`SS_16V5, `SS_8V25, `SS_3V3, `SS_1V65};
        return {i, (i[2:1] == 2'h3) ? 3'h7 : i + 3'h1, (i[2:1] == 2'h3) ? 7'h32 : 7'h14 + 7'h05 * {4'h0, i},
                lvl[i[1:0]], ss[i[1:0]], i[0] ? 12'h190 : 12'h960, i[0] ? 5'h01 : 5'h19, i[0]};
    endfunction

    function automatic nvm_bank_pkg::conv_cfg_t c_exp(input logic [2:0] i);
        logic [9:0] lvl [8] = '{`LVL_OFF, `LVL_0V98, `LVL_1V1, `LVL_1V2, `LVL_1V25, `LVL_3V3, `LVL_3V3, `LVL_3V3};
        logic [6:0] pk [4] = '{`PK_4A0, `PK_5A0, `PK_6A0, `PK_7A2};
        logic [10:0] ss [4] = '{`SS_8V7, `SS_4V35, `SS_1V75, `SS_0V87};
        return {i, (i[2:1] == 2'h3) ? 3'h7 : i + 3'h1, pk[i[1:0]], lvl[i], ss[i[1:0]], 12'h960,
                i[0] ? 5'h01 : 5'h19, i[0]};
    endfunction

    // ****************************************************************
    // Clock, timeout and scenarios
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("BAD timeout expected finish seen hang");
            tally_and_finish();
        end
    end

    initial begin
        resetn = 1'b0;
        prog_state = 1'b0;
        prog_done = 1'b0;
        seq_up = 1'b0;
        seq_down = 1'b0;
        vbat = 1'b0;
        fault_a = '0;
        fault_b = '0;
        fault_c = '0;
        fmask = '0;
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("cfg_a reset", cfg_a, ab_exp(3'h0));
        chk("cfg_c reset", cfg_c, c_exp(3'h0));
        rdc(`OFS_USER, 24'h000000);
        wr(`OFS_CONV_A, 24'hFFFFFF, 1'b1);
        rdc(`OFS_CONV_A, 24'h000000);
        prog_state = 1'b1;
        wr(7'h0E, 24'h123450, 1'b1);
        rdc(7'h0E, 24'h000000);
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            wab = {4'h0, k[0], k[1:0], k, k, k, k[0], k[1:0], k[0], 4'h0};
            wc = {4'h0, k[0], k, k, k, k[1:0], k[0], k[1:0], k[0], 4'h0};
            wr(`OFS_CONV_A, wab | 24'hF00000, 1'b0);
            wr(`OFS_CONV_B, wab, 1'b0);
            wr(`OFS_CONV_C, wc, 1'b0);
            rdc(`OFS_CONV_A, wab);
            rdc(`OFS_CONV_C, wc);
            chk("cfg_a", cfg_a, ab_exp(k));
            chk("cfg_b", cfg_b, ab_exp(k));
            chk("cfg_c", cfg_c, c_exp(k));
        end
        vbat = 1'b1;
        fault_a = 5'h10;
        fault_b = 5'h10;
        fault_c = 5'h10;
        @(negedge clk_sys);
        chk("bypass off", bypass_on, 1'b0);
        chk("recovery", {react_a[2], react_b[2], react_c[2]}, 3'h7);
        fault_a = '0;
        fault_b = '0;
        fault_c = '0;
        wr(`OFS_CONV_A, 24'h00C000, 1'b0);
        wr(`OFS_CONV_B, 24'h014000, 1'b0);
        wr(`OFS_CONV_C, 24'h002000, 1'b0);
        seq_up = 1'b1;
        seq_down = 1'b1;
        @(negedge clk_sys);
        seq_up = 1'b0;
        seq_down = 1'b0;
        @(negedge clk_sys);
        chk("up_steps", up_steps, 9'h0E9);
        chk("down_steps", down_steps, 9'h049);
        chk("bypass on", bypass_on, 1'b1);
        wr(`OFS_CONV_A, 24'h01C000, 1'b0);
        @(negedge clk_sys);
        chk("up_steps held", up_steps, 9'h0E9);
        for (int j = 0; j < 8; j++) begin
            fault_a = ft[j];
            fault_b = ft[j];
            fault_c = ft[j];
            fmask = mt[j];
            @(negedge clk_sys);
            chk("react_a", react_a, rt[j]);
            chk("react_b", react_b, rt[j]);
            chk("react_c", react_c, rt[j]);
        end
        wr(`OFS_USER, 24'hABCDEF, 1'b0);
        rdc(`OFS_USER, 24'h0BCDE0);
        chk("user word", user_word, 16'hBCDE);
        prog_done = 1'b1;
        @(negedge clk_sys);
        prog_done = 1'b0;
        chk("locked", locked, 1'b1);
        wr(`OFS_USER, 24'h000000, 1'b1);
        rdc(`OFS_USER, 24'h0BCDE0);
        tally_and_finish();
    end
endmodule
